// ==== core/rtcy_calendar.sv ====
/*
 * year and day-of-month counters with write buffers and read copies.
 * assumes a serial front end presents one-cycle register strobes, and that
 * the month counter and day/year advance ticks come from the rest of the clock.
 */
`timescale 1ns/10ps
`default_nettype none
module rtcy_calendar (
   // clock, reset, enable
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // control
   input  wire logic       bcd_mode,
   input  wire logic       write_update_request,
   input  wire logic       read_update_request,
   // calendar links
   input  wire logic [4:0] month_live,
   input  wire logic       day_advance,
   input  wire logic       year_advance,
   output logic      [7:0] year_live,
   output logic      [5:0] day_live,
   output logic            month_advance
);

   // bcd byte to binary
   function automatic logic [6:0] bcd_to_bin(input logic [7:0] v);
      bcd_to_bin = 7'(v[7:4]) * rtcy_pkg::DEC_BASE + 7'(v[3:0]);
   endfunction

   // binary to the selected format
   function automatic logic [7:0] to_fmt(input logic [6:0] b, input logic bcd);
      logic [6:0] tens;
      tens = b / rtcy_pkg::DEC_BASE;
      to_fmt = bcd ? {tens[3:0], 4'(b - tens * rtcy_pkg::DEC_BASE)} : {1'b0, b};
   endfunction

   // selected format to binary
   function automatic logic [6:0] to_bin(input logic [7:0] v, input logic bcd);
      to_bin = bcd ? bcd_to_bin(v) : v[6:0];
   endfunction

   // year and day state
   logic [7:0]           year_wbuf;
   logic [7:0]           year_count;
   logic [7:0]           year_copy;
   logic [5:0]           day_wbuf;
   logic [5:0]           day_count;
   logic [5:0]           day_copy;

   // decode and calendar arithmetic
   wire logic            hit_year  = reg_addr == rtcy_pkg::ADDR_YEAR;
   wire logic            hit_dom   = reg_addr == rtcy_pkg::ADDR_DOM;
   wire logic [6:0]      year_bin  = to_bin(year_count, bcd_mode);
   wire logic [6:0]      day_bin   = to_bin({2'b00, day_count}, bcd_mode);
   wire logic [6:0]      month_bin = to_bin({3'b000, month_live}, bcd_mode);
   wire logic            leap      = year_bin[1:0] == 2'b00;             // [R10]
   wire logic            short_mon = month_bin == 7'h04 || month_bin == 7'h06 ||
                                     month_bin == 7'h09 || month_bin == 7'h0B;
   wire logic [6:0]      last_day  = (month_bin == rtcy_pkg::MONTH_FEB) ?
                                     (leap ? rtcy_pkg::DAYS_LEAP : rtcy_pkg::DAYS_FEB) : // [R09]
                                     (short_mon ? rtcy_pkg::DAYS_SHORT :                 // [R08]
                                                  rtcy_pkg::DAYS_LONG);                  // [R07]
   wire logic            day_wrap  = day_advance && day_bin >= last_day;
   wire logic [6:0]      day_inc   = day_wrap ? 7'(rtcy_pkg::DOM_RST) : day_bin + 7'h01; // [R05]
   wire logic [6:0]      year_inc  = (year_bin >= rtcy_pkg::YEAR_MAX) ? 7'h00 :
                                     year_bin + 7'h01;                   // [R03]
   wire logic [7:0]      day_fmt   = to_fmt(day_inc, bcd_mode);          // [R06]
   wire logic [7:0]      year_fmt  = to_fmt(year_inc, bcd_mode);         // [R04] [R12]
   wire logic [7:0]      rd_word   = hit_year ? year_copy :
                                     hit_dom  ? {2'b00, day_copy} :      // [R12]
                                                rtcy_pkg::RD_UNMAPPED;

   // host write buffers; the host keeps day within the month [R11]
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         year_wbuf <= rtcy_pkg::YEAR_RST;
         day_wbuf  <= rtcy_pkg::DOM_RST;
      end else if (ce && reg_wr) begin
         if (hit_year) year_wbuf <= reg_wdata;                            // [R01]
         if (hit_dom)  day_wbuf  <= reg_wdata[5:0];
      end
   end

   // live counters; an upload beats a tick landing in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         year_count    <= rtcy_pkg::YEAR_RST;
         day_count     <= rtcy_pkg::DOM_RST;
         month_advance <= 1'b0;
      end else if (ce) begin
         month_advance <= day_wrap && !write_update_request;
         if (write_update_request) begin
            year_count <= year_wbuf;                                      // [R01]
            day_count  <= day_wbuf;
         end else begin
            if (year_advance) year_count <= year_fmt;                     // [R03] [R04]
            if (day_advance)  day_count  <= day_fmt[5:0];                 // [R07] [R08] [R09]
         end
      end
   end

   // read copies; capture takes the counter value before any same-cycle upload
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         year_copy <= rtcy_pkg::YEAR_RST;
         day_copy  <= rtcy_pkg::DOM_RST;
      end else if (ce && read_update_request) begin
         year_copy <= year_count;                                         // [R02]
         day_copy  <= day_count;
      end
   end

   // read data, registered one cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rvalid <= reg_rd;
         if (reg_rd) reg_rdata <= rd_word;
      end
   end

   assign year_live = year_count;
   assign day_live  = day_count;

   // checks
   sequence upload_s;
      ce && write_update_request;
   endsequence

   sequence year_tick_s;
      ce && year_advance && !write_update_request;
   endsequence

   sequence day_tick_s;
      ce && day_advance && !write_update_request;
   endsequence

   live_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // [R01]
      ce && !write_update_request && !year_advance && !day_advance
      |=> $stable(year_count) && $stable(day_count))
      else $error("live counters moved without upload or tick");

   live_load_a: assert property (@(posedge ref_clk) disable iff (rst) // [R01]
      upload_s |=> year_count == $past(year_wbuf) && day_count == $past(day_wbuf))
      else $error("upload did not copy the write buffers");

   copy_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
      !(ce && read_update_request) |=> $stable(year_copy) && $stable(day_copy))
      else $error("read copy changed without read update");

   copy_load_a: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
      ce && read_update_request
      |=> year_copy == $past(year_count) && day_copy == $past(day_count))
      else $error("read update did not capture the counters");

   year_wrap_a: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
      year_tick_s and (!bcd_mode && year_count == 8'h63) |=> year_count == 8'h00)
      else $error("binary year did not wrap from 99 to 0");

   bcd_carry_a: assert property (@(posedge ref_clk) disable iff (rst) // [R04]
      year_tick_s and (bcd_mode && year_count == 8'h39) |=> year_count == 8'h40)
      else $error("bcd year units did not carry into tens");

   day_wrap_a: assert property (@(posedge ref_clk) disable iff (rst) // [R08]
      day_tick_s and (day_bin == last_day)
      |=> (day_count == rtcy_pkg::DOM_RST && month_advance)
          ##1 (!month_advance || !$past(ce)))
      else $error("day did not return to 1 at month end");

   leap_feb_a: assert property (@(posedge ref_clk) disable iff (rst) // [R09]
      month_bin == rtcy_pkg::MONTH_FEB |-> last_day == (leap ? 7'h1D : 7'h1C))
      else $error("february length wrong");

   leap_rule_a: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
      day_tick_s and (month_bin == rtcy_pkg::MONTH_FEB && day_bin == rtcy_pkg::DAYS_FEB &&
                      year_bin % 7'h04 == 7'h00)
      |=> day_bin == rtcy_pkg::DAYS_LEAP && !month_advance)
      else $error("leap year february ended at 28");

   rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
      ce && reg_rd && hit_dom |=> reg_rvalid && reg_rdata[7:6] == 2'b00)
      else $error("day reserved bits not zero");

   // clock enable low must freeze the live counters, read copies, month advance and read valid
   freeze_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // [R01]
      !ce |=> $stable(year_count) && $stable(day_count) && $stable(year_copy) &&
              $stable(day_copy) && $stable(month_advance) && $stable(reg_rvalid))
      else $error("state moved while clock enable was low");

   upload_wins_a: assert property (@(posedge ref_clk) disable iff (rst) // [R01]
      upload_s |=> !month_advance)
      else $error("month advance raised during an upload");

   // reads return the copy, never the live counter
   read_copy_a: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
      ce && reg_rd && hit_year |=> reg_rvalid && reg_rdata == $past(year_copy))
      else $error("year read did not return the read copy");

   unmapped_rd_a: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
      ce && reg_rd && !hit_year && !hit_dom |=> reg_rdata == rtcy_pkg::RD_UNMAPPED)
      else $error("unmapped read not zero");

   // limits checked against literal month numbers, not the short-month decode
   short_end_a: assert property (@(posedge ref_clk) disable iff (rst) // [R08]
      day_tick_s and (day_bin == rtcy_pkg::DAYS_SHORT &&
                      (month_bin == 7'h04 || month_bin == 7'h06 ||
                       month_bin == 7'h09 || month_bin == 7'h0B))
      |=> day_bin == 7'h01 && month_advance)
      else $error("thirty-day month did not end at 30");

   leap_skip_a: assert property (@(posedge ref_clk) disable iff (rst) // [R09]
      day_tick_s and (month_bin == rtcy_pkg::MONTH_FEB && day_bin == rtcy_pkg::DAYS_FEB &&
                      year_bin % 7'h04 != 7'h00)
      |=> day_bin == 7'h01 && month_advance)
      else $error("ordinary february did not end at 28");

   bcd_digit_a: assert property (@(posedge ref_clk) disable iff (rst) // [R06]
      day_tick_s and (bcd_mode && day_count[3:0] == 4'h9 && day_bin < last_day)
      |=> day_count[3:0] == 4'h0 && day_bin == $past(day_bin) + 7'h01)
      else $error("bcd day units did not carry into tens");

endmodule
`default_nettype wire

// ==== shared/rtcy_pkg.sv ====
/*
 * constants for the year and day-of-month calendar registers:
 * register offsets, reset values, field widths and calendar limits.
 * assumes the register port is driven by an external serial front end.
 */
//
// Operation
// R01 - host writes land in a buffer and reach the live counters only on a write-update request.
// R02 - readable copies refresh from the live counters only on a read-update request.
// R03 - in binary format the eight-bit year holds 0 to 99 and the counter wraps within it.
// R04 - in BCD format the year holds two decimal digits, tens high and units low, each 0 to 9.
// R05 - in binary format the six-bit day field in bits 5 to 0 holds 1 to 31.
// R06 - in BCD format the day tens digit is 0 to 3, units 0 to 9, value nonzero and at most 31.
// R07 - months 1, 3, 5, 7, 8, 10 and 12 have days 1 to 31.
// R08 - months 4, 6, 9 and 11 have days 1 to 30.
// R09 - month 2 has days 1 to 28, or 1 to 29 in a leap year.
// R10 - a year is a leap year when its two-digit value is a multiple of four, zero included.
// R11 - the host writes only day values that fit the selected month and year.
// R12 - one format select chooses binary or BCD for both, and day bits 7 and 6 read as zero.
package rtcy_pkg;
   localparam logic [7:0] ADDR_YEAR   = 8'h0C;
   localparam logic [7:0] ADDR_DOM    = 8'h0D;
   localparam logic [7:0] YEAR_RST    = 8'h00;
   localparam logic [5:0] DOM_RST     = 6'h01;
   localparam int         DOM_W       = 6;
   localparam logic [6:0] YEAR_MAX    = 7'h63;
   localparam logic [6:0] DAYS_LONG   = 7'h1F;
   localparam logic [6:0] DAYS_SHORT  = 7'h1E;
   localparam logic [6:0] DAYS_FEB    = 7'h1C;
   localparam logic [6:0] DAYS_LEAP   = 7'h1D;
   localparam logic [6:0] MONTH_FEB   = 7'h02;
   localparam logic [6:0] DEC_BASE    = 7'h0A;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// ==== verif/rtcy_host.sv ====
/* host model: register writes and reads over the strobe port.
   assumes the calendar answers a read within four cycles of the edge that takes the strobe. */
`timescale 1ns/10ps
`default_nettype none
module rtcy_host (
   // clock
   input  wire logic       ref_clk,
   // register port
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // idle bus at time zero
   initial begin
      {reg_wr, reg_rd} = 2'h0;
      {reg_addr, reg_wdata} = 16'h0000;
   end
   // lines inverted after a strobe, so no stale value passes for a held one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // read, answer awaited a bounded number of cycles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ==== verif/rtcy_calendar_tb.sv ====
/* bench: year and day registers against an integer model.
   assumes month driven in the selected format. */
`timescale 1ns/10ps
`default_nettype none
module rtc_year_and_day_of_month_regs_tb_top;
   logic       ref_clk = 1'b0;
   logic       rst, bcd, wup, rup, dadv, yadv, wr, rd, rv, ma_s, en = 1'b1;
   logic [4:0] mon;
   logic [5:0] dl_s;
   logic [7:0] addr, wd, rdat, yl_s, d8, lf = 8'h5B;
   int         yb, db, yl, dl, yc, dc, ma, num_errors, n_compared;
   int         ml[8] = '{2, 2, 4, 6, 9, 11, 1, 12};
   int         yt[3] = '{99, 'h99, 'h39};
   always #2.5 ref_clk = ~ref_clk;
   rtcy_calendar i_dut (.ref_clk(ref_clk), .rst(rst), .ce(en), .reg_addr(addr),
      .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv),
      .bcd_mode(bcd), .write_update_request(wup), .read_update_request(rup),
      .month_live(mon), .day_advance(dadv), .year_advance(yadv), .year_live(yl_s),
      .day_live(dl_s), .month_advance(ma_s));
   rtcy_host i_host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
      .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv));
   function automatic int rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return int'(lf);
   endfunction
   function automatic int lastd(int m, int y);
      if (m == 2) return (y % 4 == 0) ? 29 : 28;
      return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
   endfunction
   function automatic int nyear(int y);
      if (bcd !== 1'b1) return (y >= 99) ? 0 : y + 1;
      if (y == 'h99) return 0;
      return (y % 16 == 9) ? y + 7 : y + 1;
   endfunction
   // format conversion of the model, identity in binary mode
   function automatic int bin(int v);
      return (bcd === 1'b1) ? v / 16 * 10 + v % 16 : v;
   endfunction
   function automatic int fmt(int v);
      return (bcd === 1'b1) ? v / 10 * 16 + v % 10 : v;
   endfunction
   task automatic chk(input string nm, input logic [7:0] s, input int e);
      n_compared++;
      if (s !== 8'(e)) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, 8'(e), s);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      i_host.wr(a, d);
      if (a == 8'h0C) yb = d;
      if (a == 8'h0D) db = d % 64;
   endtask
   task automatic rdchk(input logic [7:0] a);
      i_host.rd(a, d8);
      chk("rdata", d8, a == 8'h0C ? yc : a == 8'h0D ? dc : 0);
      chk("rvalid", {7'h00, rv}, 1);
   endtask
   // one control pulse, then live counters compared with the model
   task automatic pulse(input int k);
      @(posedge ref_clk);
      case (k)
         0: wup <= 1'b1;
         1: rup <= 1'b1;
         2: dadv <= 1'b1;
         3: yadv <= 1'b1;
         default: {en, yadv} <= 2'b01;
      endcase
      @(posedge ref_clk);
      {en, wup, rup, dadv, yadv} <= 5'h10;
      ma = (k == 2 && bin(dl) >= lastd(bin(int'(mon)), bin(yl))) ? 1 : 0;
      if (k == 1) {yc, dc} = {yl, dl};
      if (k == 2) dl = ma ? 1 : fmt(bin(dl) + 1);
      if (k == 3) yl = nyear(yl);
      if (k == 0) {yl, dl} = {yb, db};
      #1;
      chk("year_live", yl_s, yl);
      chk("day_live", {2'b00, dl_s}, dl);
      chk("month_advance", {7'h00, ma_s}, ma);
   endtask
   task finish_test;
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
   // main sequence
   initial begin
      {rst, bcd, wup, rup, dadv, yadv} = 6'h20;
      mon = 5'h01;
      db = 1;
      dl = 1;
      dc = 1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk(8'h0C);
      rdchk(8'h0D);
      rdchk(8'h3F);
      put(8'h0C, 8'h25);
      put(8'h0D, 8'hDE);
      rdchk(8'h0C);
      pulse(0);
      rdchk(8'h0D);
      pulse(1);
      rdchk(8'h0C);
      rdchk(8'h0D);
      // month ends, leap and ordinary february first
      for (int k = 0; k < 8; k++) begin
         @(posedge ref_clk);
         mon <= 5'(ml[k]);
         put(8'h0C, k < 2 ? 8'((rnd() % 25) * 4 + k) : 8'(rnd() % 100));
         put(8'h0D, 8'(lastd(ml[k], yb) - 1));
         pulse(0);
         pulse(2);
         pulse(2);
      end
      // year wrap in binary, then wrap and digit carry in bcd
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk);
         bcd <= k > 0;
         put(8'h0C, 8'(yt[k]));
         pulse(0);
         pulse(3);
      end
      // bcd day carry and thirty-day month end, then a tick lost to a low enable
      @(posedge ref_clk);
      mon <= 5'h11;
      put(8'h0D, 8'h29);
      pulse(0);
      pulse(2);
      pulse(2);
      pulse(4);
      finish_test();
   end
endmodule
`default_nettype wire
